// [include/dct_regs.svh]
// Timing counts, field positions and reset values for the command timing link
`ifndef DCT_REGS_SVH
`define DCT_REGS_SVH

// Link clock period in picoseconds (10 MHz)
`define DCT_CLK_PERIOD_PS 100000
// Precharge period in picoseconds
`define DCT_PRECHARGE_PERIOD_PS 15000
// Precharge period rounded up to whole clock cycles
`define DCT_PRECHARGE_CYCLES ((`DCT_PRECHARGE_PERIOD_PS + `DCT_CLK_PERIOD_PS - 1) / `DCT_CLK_PERIOD_PS)
// Write data length in clock cycles after a write command
`define DCT_BURST_CYCLES 2
// Write to read delay in actual clock counts
`define DCT_WTR_CYCLES 2
// Clock enable must be registered on this many rising edges
`define DCT_CKE_HOLD_EDGES 3
// Power-down exit to activate, in actual clock counts
`define DCT_XP_CYCLES 2
// Termination turn-on delay, both speed classes
`define DCT_TERM_ON_CYCLES 2
// Termination turn-off delay, faster classes: half a period after the second falling edge
`define DCT_TERM_OFF_FAST_HALF 4
`define DCT_TERM_OFF_FAST_CYCLES ((`DCT_TERM_OFF_FAST_HALF + 1) / 2)
// Termination turn-off delay, slower classes: two and a half periods, rounded up
`define DCT_TERM_OFF_SLOW_HALF 5
`define DCT_TERM_OFF_SLOW_CYCLES ((`DCT_TERM_OFF_SLOW_HALF + 1) / 2)
// Write recovery field in the mode register set address
`define DCT_WR_FIELD_LSB 9
`define DCT_WR_FIELD_MSB 11
// Write recovery field reset value (code 1 means two cycles)
`define DCT_WR_FIELD_RESET 3'h1

`endif

// [include/dct_pkg.sv]
// Types and helper functions shared by both ends of the command timing link
package dct_pkg;

   // Command on the link, one-hot
   typedef enum logic [6:0] {
      DCT_CMD_NOP = 7'h01,
      DCT_CMD_ACT = 7'h02,
      DCT_CMD_WR = 7'h04,
      DCT_CMD_WRA = 7'h08,
      DCT_CMD_RD = 7'h10,
      DCT_CMD_PRE = 7'h20,
      DCT_CMD_MRS = 7'h40
   } dct_cmd_e;

   // Termination state, one-hot
   typedef enum logic [5:0] {
      DCT_TERM_HIZ = 6'h01,
      DCT_TERM_ON_WAIT = 6'h02,
      DCT_TERM_TURNING_ON = 6'h04,
      DCT_TERM_ON = 6'h08,
      DCT_TERM_OFF_WAIT = 6'h10,
      DCT_TERM_TURNING_OFF = 6'h20
   } dct_term_e;

   typedef logic [3:0] dct_count_t;

   // Down-counter load for a spacing of n edges: reaches zero on the n-th edge
   function automatic dct_count_t dct_load(input dct_count_t n);
   begin
      dct_load = (n == 4'h0) ? 4'h0 : n - 4'h1;
   end
   endfunction

   // Write recovery cycles from the mode register field code
   function automatic dct_count_t dct_wr_cycles(input logic [2:0] code);
   begin
      dct_wr_cycles = {1'b0, code} + 4'h1;
   end
   endfunction

endpackage

// [include/dct_link_if.sv]
// Command link between the memory controller and the memory device
`timescale 1ns/10ps
`default_nettype none

interface dct_link_if;
   import dct_pkg::*;

   logic cke;
   dct_cmd_e cmd;
   logic [1:0] bank;
   logic [12:0] addr;
   logic termination_control;

   modport ctrl (output cke, output cmd, output bank, output addr, output termination_control);
   modport dev (input cke, input cmd, input bank, input addr, input termination_control);
endinterface

`default_nettype wire

// [core/dct_device.sv]
// Memory device end: mode register, termination timing and command spacing checks
`timescale 1ns/10ps
`default_nettype none
`include "dct_regs.svh"

module dct_device
   import dct_pkg::*;
(
   // Clock, reset, clock enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Link from the controller
   dct_link_if.dev lnk,
   // Speed class select, high for the faster classes
   input wire logic speed_fast,
   // Termination status
   output var dct_term_e term_state,
   output logic term_resistance_on,
   // Mode and power status
   output dct_count_t wr_recovery,
   output logic powered_down,
   // Per-command outcome pulses, plus the clock enable hold violation pulse
   output logic cmd_accepted,
   output logic dal_violation,
   output logic wtr_violation,
   output logic xp_violation,
   output logic cke_violation
);

   // ==========================================================
   // Constants
   localparam dct_count_t PRECHARGE_CYCLES = 4'(`DCT_PRECHARGE_CYCLES);
   localparam dct_count_t WTR_LOAD = 4'(`DCT_BURST_CYCLES + `DCT_WTR_CYCLES);
   localparam dct_count_t CKE_HOLD = 4'(`DCT_CKE_HOLD_EDGES);
   localparam dct_count_t XP_CYCLES = 4'(`DCT_XP_CYCLES);
   localparam dct_count_t TERM_ON = 4'(`DCT_TERM_ON_CYCLES);
   localparam dct_count_t TERM_OFF_FAST = 4'(`DCT_TERM_OFF_FAST_CYCLES);
   localparam dct_count_t TERM_OFF_SLOW = 4'(`DCT_TERM_OFF_SLOW_CYCLES);

   // ==========================================================
   // Command timing state
   logic cke_prev;
   dct_count_t cke_hold;
   dct_count_t xp_cnt;
   dct_count_t wtr_cnt;
   dct_count_t dal_cnt [4];
   logic next_cke_prev;
   dct_count_t next_cke_hold;
   dct_count_t next_xp_cnt;
   dct_count_t next_wtr_cnt;
   dct_count_t next_dal_cnt [4];
   dct_count_t next_wr_recovery;
   logic next_powered_down;
   logic next_cmd_accepted;
   logic next_dal_violation;
   logic next_wtr_violation;
   logic next_xp_violation;
   logic next_cke_violation;

   // Next values for spacing counters; only clock edges with ce high count
   always_comb
   begin
      next_cke_prev = lnk.cke;
      next_cke_hold = cke_hold;
      next_xp_cnt = xp_cnt;
      next_wtr_cnt = wtr_cnt;
      next_wr_recovery = wr_recovery;
      next_powered_down = !lnk.cke;
      next_cmd_accepted = 1'b0;
      next_dal_violation = 1'b0;
      next_wtr_violation = 1'b0;
      next_xp_violation = 1'b0;
      next_cke_violation = 1'b0;
      for (int b = 0; b < 4; b++)
      begin
         next_dal_cnt[b] = (dal_cnt[b] != 4'h0) ? dal_cnt[b] - 4'h1 : 4'h0;
      end
      if (xp_cnt != 4'h0)
      begin
         next_xp_cnt = xp_cnt - 4'h1;
      end
      if (wtr_cnt != 4'h0)
      begin
         next_wtr_cnt = wtr_cnt - 4'h1;
      end
      // Level change before three registering edges breaks the hold
      if (lnk.cke != cke_prev)
      begin
         next_cke_hold = 4'h1;
         next_cke_violation = (cke_hold < CKE_HOLD);
         if (lnk.cke)
         begin
            next_xp_cnt = dct_load(XP_CYCLES);
         end
      end
      else if (cke_hold < CKE_HOLD)
      begin
         next_cke_hold = cke_hold + 4'h1;
      end
      // Commands count only while clock enable was and is high
      if (lnk.cke && cke_prev)
      begin
         case (lnk.cmd)
            DCT_CMD_ACT:
            begin
               next_cmd_accepted = 1'b1;
               next_dal_violation = (dal_cnt[lnk.bank] != 4'h0);
               next_xp_violation = (xp_cnt != 4'h0);
            end
            DCT_CMD_WR, DCT_CMD_WRA:
            begin
               next_cmd_accepted = 1'b1;
               next_wtr_cnt = dct_load(WTR_LOAD);
               if (lnk.cmd == DCT_CMD_WRA)
               begin
                  next_dal_cnt[lnk.bank] = dct_load(wr_recovery + PRECHARGE_CYCLES);
               end
            end
            DCT_CMD_RD:
            begin
               next_cmd_accepted = 1'b1;
               next_wtr_violation = (wtr_cnt != 4'h0);
            end
            DCT_CMD_PRE:
            begin
               next_cmd_accepted = 1'b1;
            end
            DCT_CMD_MRS:
            begin
               next_cmd_accepted = 1'b1;
               next_wr_recovery = dct_wr_cycles(lnk.addr[`DCT_WR_FIELD_MSB:`DCT_WR_FIELD_LSB]);
            end
            default:
            begin
               next_cmd_accepted = 1'b0;
            end
         endcase
      end
   end

   // Register command timing state
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cke_prev <= 1'b0;
         cke_hold <= CKE_HOLD;
         xp_cnt <= 4'h0;
         wtr_cnt <= 4'h0;
         dal_cnt <= '{default: 4'h0};
         wr_recovery <= dct_wr_cycles(`DCT_WR_FIELD_RESET);
         powered_down <= 1'b1;
         cmd_accepted <= 1'b0;
         dal_violation <= 1'b0;
         wtr_violation <= 1'b0;
         xp_violation <= 1'b0;
         cke_violation <= 1'b0;
      end
      else if (ce)
      begin
         cke_prev <= next_cke_prev;
         cke_hold <= next_cke_hold;
         xp_cnt <= next_xp_cnt;
         wtr_cnt <= next_wtr_cnt;
         dal_cnt <= next_dal_cnt;
         wr_recovery <= next_wr_recovery;
         powered_down <= next_powered_down;
         cmd_accepted <= next_cmd_accepted;
         dal_violation <= next_dal_violation;
         wtr_violation <= next_wtr_violation;
         xp_violation <= next_xp_violation;
         cke_violation <= next_cke_violation;
      end
   end

   // ==========================================================
   // Termination timing
   logic term_prev;
   dct_count_t term_cnt;
   logic next_term_prev;
   dct_count_t next_term_cnt;
   dct_term_e next_term_state;
   logic next_term_resistance_on;
   dct_count_t off_delay;

   // Slow classes round the half period up: a whole-cycle clock has no falling-edge timing
   assign off_delay = speed_fast ? TERM_OFF_FAST : TERM_OFF_SLOW;

   // Next termination state; a new first edge restarts the delay from that edge
   always_comb
   begin
      next_term_prev = lnk.termination_control;
      next_term_state = term_state;
      next_term_cnt = (term_cnt != 4'h0) ? term_cnt - 4'h1 : 4'h0;
      if (lnk.termination_control && !term_prev)
      begin
         next_term_state = DCT_TERM_ON_WAIT;
         next_term_cnt = dct_load(TERM_ON);
      end
      else if (!lnk.termination_control && term_prev)
      begin
         next_term_state = DCT_TERM_OFF_WAIT;
         next_term_cnt = dct_load(off_delay);
      end
      else
      begin
         case (term_state)
            DCT_TERM_HIZ: next_term_state = DCT_TERM_HIZ;
            DCT_TERM_ON_WAIT: next_term_state = (term_cnt == 4'h0) ? DCT_TERM_TURNING_ON : DCT_TERM_ON_WAIT;
            DCT_TERM_TURNING_ON: next_term_state = DCT_TERM_ON;
            DCT_TERM_ON: next_term_state = DCT_TERM_ON;
            DCT_TERM_OFF_WAIT: next_term_state = (term_cnt == 4'h0) ? DCT_TERM_TURNING_OFF : DCT_TERM_OFF_WAIT;
            DCT_TERM_TURNING_OFF: next_term_state = DCT_TERM_HIZ;
            default: next_term_state = DCT_TERM_HIZ;
         endcase
      end
      // Resistance counts as present from turn-on begin until turn-off completes
      next_term_resistance_on = (next_term_state == DCT_TERM_TURNING_ON) || (next_term_state == DCT_TERM_ON) ||
                                (next_term_state == DCT_TERM_OFF_WAIT) || (next_term_state == DCT_TERM_TURNING_OFF);
   end

   // Register termination state
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         term_prev <= 1'b0;
         term_cnt <= 4'h0;
         term_state <= DCT_TERM_HIZ;
         term_resistance_on <= 1'b0;
      end
      else if (ce)
      begin
         term_prev <= next_term_prev;
         term_cnt <= next_term_cnt;
         term_state <= next_term_state;
         term_resistance_on <= next_term_resistance_on;
      end
   end

endmodule

`default_nettype wire

// [core/dct_controller.sv]
// Memory controller end: command spacing counters, clock enable and termination drive
`timescale 1ns/10ps
`default_nettype none
`include "dct_regs.svh"

module dct_controller
   import dct_pkg::*;
(
   // Clock, reset, clock enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Link to the device
   dct_link_if.ctrl lnk,
   // Command request
   input wire logic req_valid,
   input wire dct_cmd_e req_cmd,
   input wire logic [1:0] req_bank,
   input wire logic [12:0] req_addr,
   output logic req_done,
   // Power and termination requests
   input wire logic powerdown_request,
   input wire logic term_request,
   output logic clock_change_ok,
   // Write data fault report
   input wire logic data_setup_failed,
   input wire logic [1:0] failed_bank,
   output logic [3:0] bank_corrupt
);

   // ==========================================================
   // Constants
   localparam dct_count_t PRECHARGE_CYCLES = 4'(`DCT_PRECHARGE_CYCLES);
   localparam dct_count_t WTR_LOAD = 4'(`DCT_BURST_CYCLES + `DCT_WTR_CYCLES);
   localparam dct_count_t CKE_HOLD = 4'(`DCT_CKE_HOLD_EDGES);
   localparam dct_count_t XP_CYCLES = 4'(`DCT_XP_CYCLES);

   // ==========================================================
   // State
   dct_count_t cke_hold;
   dct_count_t xp_cnt;
   dct_count_t wtr_cnt;
   dct_count_t dal_cnt [4];
   dct_count_t wr_shadow;
   logic cke_was;
   logic allowed;
   logic cke_change;
   logic issue;
   dct_count_t next_cke_hold;
   dct_count_t next_xp_cnt;
   dct_count_t next_wtr_cnt;
   dct_count_t next_dal_cnt [4];
   dct_count_t next_wr_shadow;
   logic [3:0] next_bank_corrupt;

   // Commands wait on their counters; read also waits on a rewrite of a corrupted bank
   always_comb
   begin
      case (req_cmd)
         DCT_CMD_ACT: allowed = (dal_cnt[req_bank] == 4'h0) && (xp_cnt == 4'h0);
         DCT_CMD_RD: allowed = (wtr_cnt == 4'h0) && !bank_corrupt[req_bank];
         DCT_CMD_NOP: allowed = 1'b0;
         default: allowed = 1'b1;
      endcase
   end

   // Clock enable toggles only after three registering edges and never with a command
   assign cke_change = (powerdown_request == lnk.cke) && (cke_hold >= CKE_HOLD) && !(req_valid && !req_done);
   assign issue = req_valid && !req_done && lnk.cke && cke_was && !cke_change && allowed;

   // Next counter values, loads take priority over the count-down
   always_comb
   begin
      next_cke_hold = (cke_hold < CKE_HOLD) ? cke_hold + 4'h1 : cke_hold;
      next_xp_cnt = (xp_cnt != 4'h0) ? xp_cnt - 4'h1 : 4'h0;
      next_wtr_cnt = (wtr_cnt != 4'h0) ? wtr_cnt - 4'h1 : 4'h0;
      next_wr_shadow = wr_shadow;
      next_bank_corrupt = bank_corrupt;
      for (int b = 0; b < 4; b++)
      begin
         next_dal_cnt[b] = (dal_cnt[b] != 4'h0) ? dal_cnt[b] - 4'h1 : 4'h0;
      end
      if (cke_change)
      begin
         next_cke_hold = 4'h1;
         if (!lnk.cke)
         begin
            next_xp_cnt = dct_load(XP_CYCLES);
         end
      end
      if (issue)
      begin
         if ((req_cmd == DCT_CMD_WR) || (req_cmd == DCT_CMD_WRA))
         begin
            next_wtr_cnt = dct_load(WTR_LOAD);
            next_bank_corrupt[req_bank] = 1'b0;
         end
         if (req_cmd == DCT_CMD_WRA)
         begin
            next_dal_cnt[req_bank] = dct_load(wr_shadow + PRECHARGE_CYCLES);
         end
         if (req_cmd == DCT_CMD_MRS)
         begin
            next_wr_shadow = dct_wr_cycles(req_addr[`DCT_WR_FIELD_MSB:`DCT_WR_FIELD_LSB]);
         end
      end
      // A new fault wins over a rewrite in the same cycle
      if (data_setup_failed)
      begin
         next_bank_corrupt[failed_bank] = 1'b1;
      end
   end

   // Register state and link outputs
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cke_hold <= 4'h0;
         xp_cnt <= 4'h0;
         wtr_cnt <= 4'h0;
         dal_cnt <= '{default: 4'h0};
         wr_shadow <= dct_wr_cycles(`DCT_WR_FIELD_RESET);
         bank_corrupt <= 4'h0;
         cke_was <= 1'b0;
         req_done <= 1'b0;
         clock_change_ok <= 1'b0;
         lnk.cke <= 1'b0;
         lnk.cmd <= DCT_CMD_NOP;
         lnk.bank <= 2'h0;
         lnk.addr <= 13'h0000;
         lnk.termination_control <= 1'b0;
      end
      else if (ce)
      begin
         cke_hold <= next_cke_hold;
         xp_cnt <= next_xp_cnt;
         wtr_cnt <= next_wtr_cnt;
         dal_cnt <= next_dal_cnt;
         wr_shadow <= next_wr_shadow;
         bank_corrupt <= next_bank_corrupt;
         cke_was <= lnk.cke;
         req_done <= issue;
         // Frequency may change only once the low level is fully registered
         clock_change_ok <= !(cke_change ? !lnk.cke : lnk.cke) && (next_cke_hold >= CKE_HOLD);
         lnk.cke <= cke_change ? !lnk.cke : lnk.cke;
         lnk.cmd <= issue ? req_cmd : DCT_CMD_NOP;
         lnk.bank <= issue ? req_bank : lnk.bank;
         lnk.addr <= issue ? req_addr : lnk.addr;
         lnk.termination_control <= term_request;
      end
   end

endmodule

`default_nettype wire

// [testbench/dct_sva.sv]
// Concurrent checks on the command timing link between the two ends
`timescale 1ns/10ps
`default_nettype none
module dct_sva
   import dct_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Link signals
   input wire logic cke,
   input wire dct_cmd_e cmd,
   input wire logic [1:0] bank,
   input wire logic [12:0] addr,
   input wire logic termination_control
);
   logic [2:0] wr_code;
   logic [2:0] next_wr_code;
   logic [3:0] dal_cnt;
   logic [3:0] next_dal_cnt;
   logic [1:0] dal_bank;
   logic [1:0] next_dal_bank;
   // ==========================================
   // Shadow recovery code and activate blackout
   // Only the last bank written with precharge is tracked
   always_comb
   begin
      next_wr_code = (cmd == DCT_CMD_MRS) ? addr[11:9] : wr_code;
      next_dal_cnt = (dal_cnt != 4'h0) ? dal_cnt - 4'h1 : 4'h0;
      next_dal_bank = dal_bank;
      if (cmd == DCT_CMD_WRA)
      begin
         next_dal_cnt = {1'b0, wr_code} + 4'h1;
         next_dal_bank = bank;
      end
   end
   // Register the shadow state
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_code <= 3'h1;
         dal_cnt <= 4'h0;
         dal_bank <= 2'h0;
      end
      else
      begin
         wr_code <= next_wr_code;
         dal_cnt <= next_dal_cnt;
         dal_bank <= next_dal_bank;
      end
   end
   // ==========================================
   // Assertions
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_cke_hold;
      $changed(cke) |=> $stable(cke) [*2];
   endproperty
   a_cke_hold: assert property (p_cke_hold) else $error("clock enable changed early");
   property p_cke_rise;
      $rose(cke) |-> !$past(cke, 2) && !$past(cke, 3);
   endproperty
   a_cke_rise: assert property (p_cke_rise) else $error("clock enable low too briefly");
   property p_wtr;
      cmd == DCT_CMD_WR |=> (cmd != DCT_CMD_RD) [*3];
   endproperty
   a_wtr: assert property (p_wtr) else $error("read too soon after write");
   property p_xp;
      $rose(cke) |-> cmd != DCT_CMD_ACT ##1 cmd != DCT_CMD_ACT;
   endproperty
   a_xp: assert property (p_xp) else $error("activate too soon after exit");
   property p_dal;
      cmd == DCT_CMD_ACT && bank == dal_bank |-> dal_cnt == 4'h0;
   endproperty
   a_dal: assert property (p_dal) else $error("activate inside recovery window");
   property p_idle_low;
      !cke |-> cmd == DCT_CMD_NOP;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("command while clock enable low");
   property p_single;
      cmd != DCT_CMD_NOP |=> cmd == DCT_CMD_NOP;
   endproperty
   a_single: assert property (p_single) else $error("command longer than a cycle");
   property p_hold_addr;
      cmd == DCT_CMD_NOP |-> $stable(bank) && $stable(addr);
   endproperty
   a_hold_addr: assert property (p_hold_addr) else $error("bank or address moved while idle");
endmodule
`default_nettype wire

// [testbench/ddr2_command_cycle_timing_bench.sv]
// Self-checking bench joining both ends of the command timing link
`timescale 1ns/10ps
`default_nettype none
module ddr2_command_cycle_timing_bench
   import dct_pkg::*;
;
   typedef struct {
      dct_cmd_e cmd;
      logic [1:0] bank;
      logic [12:0] addr;
      int gap;
      dct_count_t wr;
   } dct_row_s;
   // Request, expected edge spacing from the previous one, recovery after it
   dct_row_s rows [10] = '{
      '{DCT_CMD_MRS, 2'h0, 13'h0600, 0, 4'h4},
      '{DCT_CMD_ACT, 2'h0, 13'h0000, 3, 4'h4},
      '{DCT_CMD_WRA, 2'h0, 13'h0000, 3, 4'h4},
      '{DCT_CMD_ACT, 2'h0, 13'h0000, 5, 4'h4},
      '{DCT_CMD_WR, 2'h1, 13'h0000, 3, 4'h4},
      '{DCT_CMD_RD, 2'h1, 13'h0000, 4, 4'h4},
      '{DCT_CMD_PRE, 2'h1, 13'h0000, 3, 4'h4},
      '{DCT_CMD_MRS, 2'h0, 13'h0200, 3, 4'h2},
      '{DCT_CMD_WRA, 2'h2, 13'h0000, 3, 4'h2},
      '{DCT_CMD_ACT, 2'h2, 13'h0000, 3, 4'h2}};
   logic [6:0] on_exp [4] = '{7'h02, 7'h02, 7'h44, 7'h48};
   logic [6:0] off_exp [2][5] = '{'{7'h50, 7'h50, 7'h50, 7'h60, 7'h01}, '{7'h50, 7'h50, 7'h60, 7'h01, 7'h01}};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic fast = 1'b1;
   logic b_fast = 1'b0;
   logic req_valid = 1'b0;
   dct_cmd_e req_cmd = DCT_CMD_NOP;
   logic [1:0] req_bank = 2'h0;
   logic [12:0] req_addr = 13'h0000;
   logic pd_req = 1'b0;
   logic term_req = 1'b0;
   logic dsf = 1'b0;
   logic [1:0] fbank = 2'h0;
   logic req_done, ccok, pdown, b_res, ok;
   logic [3:0] corrupt;
   dct_term_e term_state;
   dct_term_e b_term;
   dct_count_t wr_rec;
   dct_count_t b_wr;
   logic acc, dal, wtr, xpv;
   logic b_acc, b_dal, b_wtr, b_xp, b_ckv;
   int cyc = 0;
   int last = 0;
   int n;
   int mismatches = 0;
   int check_count = 0;
   // ==========================================
   // Both ends on one link, a second device driven by the bench
   dct_link_if lnk();
   dct_link_if l2();
   dct_controller i_dct_controller (.clk(clk), .rst_n(rst_n), .ce(ce), .lnk(lnk), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_done(req_done),
      .powerdown_request(pd_req), .term_request(term_req), .clock_change_ok(ccok),
      .data_setup_failed(dsf), .failed_bank(fbank), .bank_corrupt(corrupt));
   dct_device i_dct_device (.clk(clk), .rst_n(rst_n), .ce(ce), .lnk(lnk), .speed_fast(fast),
      .term_state(term_state), .term_resistance_on(), .wr_recovery(wr_rec), .powered_down(pdown),
      .cmd_accepted(acc), .dal_violation(dal), .wtr_violation(wtr), .xp_violation(xpv), .cke_violation());
   dct_device i_dct_device_b (.clk(clk), .rst_n(rst_n), .ce(ce), .lnk(l2), .speed_fast(b_fast),
      .term_state(b_term), .term_resistance_on(b_res), .wr_recovery(b_wr), .powered_down(),
      .cmd_accepted(b_acc), .dal_violation(b_dal), .wtr_violation(b_wtr), .xp_violation(b_xp),
      .cke_violation(b_ckv));
   dct_sva i_dct_sva (.clk(clk), .rst_n(rst_n), .cke(lnk.cke), .cmd(lnk.cmd), .bank(lnk.bank),
      .addr(lnk.addr), .termination_control(lnk.termination_control));
   // Clock and edge counter
   always #50 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // ==========================================
   // Shared tasks
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
   begin
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   end
   endtask
   // Blocked requests give up after a bounded wait
   task automatic issue(input dct_cmd_e c, input logic [1:0] b, input logic [12:0] a, output logic got);
   begin
      @(posedge clk);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_bank <= b;
      req_addr <= a;
      got = 1'b0;
      for (int i = 0; i < 12 && !got; i++)
      begin
         @(posedge clk);
         #1;
         got = (req_done === 1'b1);
      end
      if (!got)
         req_valid <= 1'b0;
   end
   endtask
   // One command on the second link, gap + 1 idle edges after the previous one
   task automatic drv(input dct_cmd_e c, input logic [1:0] b, input logic [12:0] a, input int gap,
      input logic [3:0] exp, input logic [3:0] msk);
   begin
      repeat (gap + 1) @(posedge clk);
      l2.cmd <= c;
      l2.bank <= b;
      l2.addr <= a;
      @(posedge clk);
      l2.cmd <= DCT_CMD_NOP;
      #1;
      chk("device outcome", 16'(exp & msk), 16'({b_acc, b_dal, b_wtr, b_xp} & msk));
   end
   endtask
   task automatic cke2(input logic v);
   begin
      @(posedge clk);
      l2.cke <= v;
   end
   endtask
   task automatic close_out;
   begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   // Watchdog, far beyond the roughly 150 edges the run needs
   initial
   begin
      repeat (4000) @(posedge clk);
      mismatches++;
      $display("watchdog expired");
      close_out();
   end
   // ==========================================
   // Main sequence
   initial
   begin
      l2.cke = 1'b0;
      l2.cmd = DCT_CMD_NOP;
      l2.bank = 2'h0;
      l2.addr = 13'h0000;
      l2.termination_control = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("reset state", 16'h0121, 16'({lnk.cke, req_done, ccok, corrupt, pdown, wr_rec, term_state[3:0]}));
      $display("reset test done");
      // Faulty traffic into the second device
      cke2(1'b1);
      drv(DCT_CMD_ACT, 2'h0, 13'h0000, 1, 4'h8, 4'hf);
      drv(DCT_CMD_MRS, 2'h0, 13'h0600, 0, 4'h8, 4'hf);
      chk("recovery code", 16'h4, 16'(b_wr));
      drv(DCT_CMD_WRA, 2'h0, 13'h0000, 0, 4'h8, 4'hf);
      drv(DCT_CMD_ACT, 2'h0, 13'h0000, 2, 4'h4, 4'h7);
      drv(DCT_CMD_WRA, 2'h0, 13'h0000, 0, 4'h8, 4'hf);
      drv(DCT_CMD_ACT, 2'h0, 13'h0000, 3, 4'h8, 4'hf);
      drv(DCT_CMD_WR, 2'h1, 13'h0000, 0, 4'h8, 4'hf);
      drv(DCT_CMD_RD, 2'h1, 13'h0000, 1, 4'h2, 4'h7);
      drv(DCT_CMD_WR, 2'h1, 13'h0000, 0, 4'h8, 4'hf);
      drv(DCT_CMD_RD, 2'h1, 13'h0000, 2, 4'h8, 4'hf);
      cke2(1'b0);
      cke2(1'b1);
      @(posedge clk);
      #1;
      chk("clock enable hold", 16'h1, 16'(b_ckv));
      repeat (3) @(posedge clk);
      cke2(1'b0);
      repeat (3) @(posedge clk);
      cke2(1'b1);
      drv(DCT_CMD_ACT, 2'h3, 13'h0000, 0, 4'h1, 4'h7);
      $display("faulty link test done");
      for (int s = 0; s < 2; s++)
      begin
         b_fast <= s[0];
         @(posedge clk);
         l2.termination_control <= 1'b1;
         for (int k = 0; k < 4; k++)
         begin
            @(posedge clk);
            #1;
            chk("termination on", 16'(on_exp[k]), 16'({b_res, b_term}));
         end
         l2.termination_control <= 1'b0;
         for (int k = 0; k < 5; k++)
         begin
            @(posedge clk);
            #1;
            chk("termination off", 16'(off_exp[s][k]), 16'({b_res, b_term}));
         end
      end
      $display("termination test done");
      // Ordinary traffic through the controller
      for (n = 0; n < 20 && lnk.cke !== 1'b1; n++)
         @(posedge clk);
      foreach (rows[i])
      begin
         issue(rows[i].cmd, rows[i].bank, rows[i].addr, ok);
         chk("request taken", 16'h1, 16'(ok));
         chk("link command", 16'(rows[i].cmd), 16'(lnk.cmd));
         if (rows[i].gap != 0)
            chk("spacing", 16'(rows[i].gap), 16'(cyc - last));
         last = cyc;
         // Device answers one edge after the command shows on the link
         @(posedge clk);
         req_valid <= 1'b0;
         #1;
         chk("device outcome", 16'h8, 16'({acc, dal, wtr, xpv}));
         chk("recovery", 16'(rows[i].wr), 16'(wr_rec));
      end
      $display("table test done");
      @(posedge clk);
      dsf <= 1'b1;
      fbank <= 2'h1;
      @(posedge clk);
      dsf <= 1'b0;
      @(posedge clk);
      #1;
      chk("corrupt flags", 16'h2, 16'(corrupt));
      issue(DCT_CMD_RD, 2'h1, 13'h0000, ok);
      chk("read held back", 16'h0, 16'(ok));
      issue(DCT_CMD_WR, 2'h1, 13'h0000, ok);
      issue(DCT_CMD_RD, 2'h1, 13'h0000, ok);
      chk("read after rewrite", 16'h1, 16'({corrupt, ok}));
      @(posedge clk);
      req_valid <= 1'b0;
      term_req <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chk("controller termination", 16'(DCT_TERM_ON), 16'(term_state));
      pd_req <= 1'b1;
      for (n = 0; n < 20 && lnk.cke !== 1'b0; n++)
         @(posedge clk);
      #1;
      chk("clock change early", 16'h0, 16'(ccok));
      repeat (6) @(posedge clk);
      #1;
      chk("clock change window", 16'h3, 16'({ccok, pdown}));
      pd_req <= 1'b0;
      issue(DCT_CMD_ACT, 2'h3, 13'h0000, ok);
      @(posedge clk);
      #1;
      chk("activate after exit", 16'h11, 16'({acc, dal, wtr, xpv, ok}));
      $display("corrupt and power test done");
      close_out();
   end
endmodule
`default_nettype wire
